// >>> hw/pfs_defines.svh
// command codes, field positions, supported masks and reset values of the status bytes
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// command codes of the status bytes
`define PFS_CMD_IOUT 8'h7B
`define PFS_CMD_INPUT 8'h7C
`define PFS_CMD_TEMP 8'h7D
`define PFS_CMD_COMM 8'h7E

// output-current byte fields
`define PFS_IOUT_OC_FAULT_BIT 7
`define PFS_IOUT_OC_WARN_BIT 5
`define PFS_IOUT_UC_FAULT_BIT 4
`define PFS_IOUT_SUPPORTED 8'hB0

// input byte fields
`define PFS_IN_OV_FAULT_BIT 7
`define PFS_IN_OV_WARN_BIT 6
`define PFS_IN_UV_WARN_BIT 5
`define PFS_IN_OFF_LIVE_BIT 3
`define PFS_IN_SUPPORTED 8'hE0

// temperature byte fields
`define PFS_TEMP_OT_FAULT_BIT 7
`define PFS_TEMP_OT_WARN_BIT 6
`define PFS_TEMP_SUPPORTED 8'hC0

// communication / logic / memory byte, every bit latched by default
`define PFS_COMM_SUPPORTED 8'hFF

// reset values
`define PFS_FLAGS_RST 8'h00
`define PFS_MASK_RST 8'h00
`define PFS_RDATA_RST 8'h00

`endif

// >>> hw/pfs_pkg.sv
// types shared by the fault status byte design
package pfs_pkg;
  typedef logic [7:0] pfs_byte_t;
  // one-hot decode of a status command code
  typedef enum logic [4:0] {
    PFS_SEL_NONE = 5'h01,
    PFS_SEL_IOUT = 5'h02,
    PFS_SEL_INPUT = 5'h04,
    PFS_SEL_TEMP = 5'h08,
    PFS_SEL_COMM = 5'h10
  } pfs_sel_t;
endpackage

// >>> hw/pfs_flag_if.sv
// bundle between the status logic and one latched flag byte
`timescale 1ns/1ps
interface pfs_flag_if;
  logic [7:0] set;
  logic [7:0] w1c;
  logic clr_all;
  logic [7:0] flags;
  modport bank (input set, input w1c, input clr_all, output flags);
  modport ctrl (output set, output w1c, output clr_all, input flags);
endinterface

// >>> hw/pfs_flag_bank.sv
// one byte of latched status flags with write-one-to-clear and clear-all
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_flag_bank #(
  parameter logic [7:0] SUPPORTED = 8'hFF
) (
  input wire logic clk,
  input wire logic rst_n,
  pfs_flag_if.bank fb
);
  import pfs_pkg::*;

  // set beats clear in the same cycle, unsupported bits stay zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb.flags <= `PFS_FLAGS_RST;
    end else begin
      fb.flags <= ((fb.flags & ~(fb.w1c | {8{fb.clr_all}})) | fb.set) & SUPPORTED;
    end
  end
endmodule

// >>> hw/pfs_status_top.sv
// fault status bytes: output current, input, temperature and comm/logic/memory
//
// Function
// RULE1: output-current byte latches overcurrent fault b7, warn b5, undercurrent fault b4
// RULE2: output-current bits 6 and 3..0 are read-only zero
// RULE3: every alert-capable bit has its own bit in the alert mask register
// RULE4: input byte latches overvoltage fault b7, warn b6, undervoltage warn b5
// RULE5: input bits 4 and 2..0 are read-only zero
// RULE6: input bit 3 is live: one means input off, zero means on
// RULE7: input off when below turn-on or 5 V rail in lockout; never alerts (once on, the code goes off only below turn-off or in lockout)
// RULE8: input-off indicator set right after reset, without alert
// RULE9: input undervoltage warning is latched and may raise the alert
// RULE10: undervoltage warning alert masked until input first passes turn-on threshold
// RULE11: temperature byte latches fault b7, warn b6; bits 5..0 read zero
// RULE12: latched bits clear on clear-faults or on a written one
// RULE13: each status byte is one byte written or read per transaction
// RULE14: code 7Ch selects input byte, 7Dh the temperature byte
// RULE15: code 7Eh selects the communication, logic and memory byte
// RULE16: summary outputs flag output-current and input faults for status word
// RULE17: each summary is the OR of its byte and clears with it
// RULE18: latched flags hold until cleared; writing zero changes nothing
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_status_top (
  input wire logic sys_clk,
  input wire logic nrst,
  // status command port from the bus front end, same clock
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire pfs_pkg::pfs_byte_t cmd_code,
  input wire pfs_pkg::pfs_byte_t cmd_wdata,
  input wire logic clear_faults,
  // alert mask command port, same clock
  input wire logic mask_write,
  input wire logic mask_read,
  input wire pfs_pkg::pfs_byte_t mask_code,
  input wire pfs_pkg::pfs_byte_t mask_wdata,
  // detector levels, asynchronous to sys_clk
  input wire logic overcurrent_fault_det,
  input wire logic overcurrent_warn_det,
  input wire logic undercurrent_fault_det,
  input wire logic input_overvoltage_fault_det,
  input wire logic input_overvoltage_warn_det,
  input wire logic input_undervoltage_warn_det,
  input wire logic power_input_above_turn_on_det,
  input wire logic power_input_below_turn_off_det,
  input wire logic internal_5v_rail_uvlo_det,
  input wire logic overtemp_fault_det,
  input wire logic overtemp_warn_det,
  // communication/logic/memory events, one-cycle pulses on sys_clk
  input wire pfs_pkg::pfs_byte_t comm_event,
  // answers
  output logic rsp_valid,
  output pfs_pkg::pfs_byte_t rsp_data,
  output logic rsp_unmapped,
  output logic alert_req,
  output logic iout_summary,
  output logic input_summary,
  output logic temp_summary,
  output logic comm_summary,
  output logic input_off_live_flag
);
  import pfs_pkg::*;

  localparam int NDET = 11;

  logic rst_meta;
  logic rst_n;
  logic [NDET-1:0] det_meta;
  logic [NDET-1:0] det_sync;
  logic uvw_armed;
  pfs_sel_t cmd_sel;
  pfs_sel_t mask_sel;
  pfs_byte_t mask_iout;
  pfs_byte_t mask_input;
  pfs_byte_t mask_temp;
  pfs_byte_t mask_comm;
  pfs_byte_t input_view;
  pfs_byte_t input_alert_mask;
  logic cmd_wr;
  logic cmd_rd;
  logic overcurrent_fault_flag;
  logic overcurrent_warn_flag;
  logic undercurrent_fault_flag;
  logic input_overvoltage_fault_flag;
  logic input_overvoltage_warn_flag;
  logic input_undervoltage_warn_flag;
  logic overtemp_fault_flag;
  logic overtemp_warn_flag;
  logic next_input_off;

  pfs_flag_if iout_fb ();
  pfs_flag_if input_fb ();
  pfs_flag_if temp_fb ();
  pfs_flag_if comm_fb ();

  // command code to byte select
  function automatic pfs_sel_t decode_code(input pfs_byte_t code);
    case (code)
      `PFS_CMD_IOUT: decode_code = PFS_SEL_IOUT;
      `PFS_CMD_INPUT: decode_code = PFS_SEL_INPUT; // [RULE14]
      `PFS_CMD_TEMP: decode_code = PFS_SEL_TEMP; // [RULE14]
      `PFS_CMD_COMM: decode_code = PFS_SEL_COMM; // [RULE15]
      default: decode_code = PFS_SEL_NONE;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // detector levels pass two flops before use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_meta <= '0;
      det_sync <= '0;
    end else begin
      det_meta <= {overcurrent_fault_det, overcurrent_warn_det, undercurrent_fault_det,
                   input_overvoltage_fault_det, input_overvoltage_warn_det,
                   input_undervoltage_warn_det, power_input_above_turn_on_det,
                   power_input_below_turn_off_det, internal_5v_rail_uvlo_det,
                   overtemp_fault_det, overtemp_warn_det};
      det_sync <= det_meta;
    end
  end

  // synchronised detector levels by name
  assign overcurrent_fault_flag = det_sync[10];
  assign overcurrent_warn_flag = det_sync[9];
  assign undercurrent_fault_flag = det_sync[8];
  assign input_overvoltage_fault_flag = det_sync[7];
  assign input_overvoltage_warn_flag = det_sync[6];
  assign input_undervoltage_warn_flag = det_sync[5];
  assign overtemp_fault_flag = det_sync[1];
  assign overtemp_warn_flag = det_sync[0];

  // request decode
  assign cmd_sel = decode_code(cmd_code);
  assign mask_sel = decode_code(mask_code);
  assign cmd_wr = cmd_valid && cmd_write;
  assign cmd_rd = cmd_valid && !cmd_write;

  // set vectors from detectors, only documented positions
  always_comb begin
    iout_fb.set = 8'h00;
    iout_fb.set[`PFS_IOUT_OC_FAULT_BIT] = overcurrent_fault_flag; // [RULE1]
    iout_fb.set[`PFS_IOUT_OC_WARN_BIT] = overcurrent_warn_flag; // [RULE1]
    iout_fb.set[`PFS_IOUT_UC_FAULT_BIT] = undercurrent_fault_flag; // [RULE1]
    input_fb.set = 8'h00;
    input_fb.set[`PFS_IN_OV_FAULT_BIT] = input_overvoltage_fault_flag; // [RULE4]
    input_fb.set[`PFS_IN_OV_WARN_BIT] = input_overvoltage_warn_flag; // [RULE4]
    input_fb.set[`PFS_IN_UV_WARN_BIT] = input_undervoltage_warn_flag; // [RULE4] [RULE9]
    temp_fb.set = 8'h00;
    temp_fb.set[`PFS_TEMP_OT_FAULT_BIT] = overtemp_fault_flag; // [RULE11]
    temp_fb.set[`PFS_TEMP_OT_WARN_BIT] = overtemp_warn_flag; // [RULE11]
    comm_fb.set = comm_event;
  end

  // written ones clear single flags, zeros do nothing
  always_comb begin
    iout_fb.w1c = (cmd_wr && cmd_sel == PFS_SEL_IOUT) ? cmd_wdata : 8'h00; // [RULE12] [RULE18]
    input_fb.w1c = (cmd_wr && cmd_sel == PFS_SEL_INPUT) ? cmd_wdata : 8'h00; // [RULE12]
    temp_fb.w1c = (cmd_wr && cmd_sel == PFS_SEL_TEMP) ? cmd_wdata : 8'h00; // [RULE12]
    comm_fb.w1c = (cmd_wr && cmd_sel == PFS_SEL_COMM) ? cmd_wdata : 8'h00; // [RULE12]
    iout_fb.clr_all = clear_faults; // [RULE12]
    input_fb.clr_all = clear_faults;
    temp_fb.clr_all = clear_faults;
    comm_fb.clr_all = clear_faults;
  end

  // latched flag bytes; unsupported positions are forced to zero
  pfs_flag_bank #(.SUPPORTED(`PFS_IOUT_SUPPORTED)) u_iout ( // [RULE2] [RULE18]
    .clk(sys_clk),
    .rst_n(rst_n),
    .fb(iout_fb)
  );
  pfs_flag_bank #(.SUPPORTED(`PFS_IN_SUPPORTED)) u_input ( // [RULE5]
    .clk(sys_clk),
    .rst_n(rst_n),
    .fb(input_fb)
  );
  pfs_flag_bank #(.SUPPORTED(`PFS_TEMP_SUPPORTED)) u_temp ( // [RULE11]
    .clk(sys_clk),
    .rst_n(rst_n),
    .fb(temp_fb)
  );
  pfs_flag_bank #(.SUPPORTED(`PFS_COMM_SUPPORTED)) u_comm (
    .clk(sys_clk),
    .rst_n(rst_n),
    .fb(comm_fb)
  );

  // live input state with turn-on / turn-off hysteresis
  always_comb begin
    if (input_off_live_flag) begin
      next_input_off = !(det_sync[4] && !det_sync[2]); // [RULE7]
    end else begin
      next_input_off = det_sync[3] || det_sync[2]; // [RULE7]
    end
  end

  // input starts off after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_off_live_flag <= 1'b1; // [RULE8]
    end else begin
      input_off_live_flag <= next_input_off; // [RULE6]
    end
  end

  // undervoltage warning alert armed once input first passes turn-on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uvw_armed <= 1'b0;
    end else if (det_sync[4]) begin
      uvw_armed <= 1'b1; // [RULE10]
    end
  end

  // alert mask registers, one bit per alert-capable status bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_iout <= `PFS_MASK_RST;
      mask_input <= `PFS_MASK_RST;
      mask_temp <= `PFS_MASK_RST;
      mask_comm <= `PFS_MASK_RST;
    end else if (mask_write) begin
      case (mask_sel)
        PFS_SEL_IOUT: mask_iout <= mask_wdata & `PFS_IOUT_SUPPORTED; // [RULE3]
        PFS_SEL_INPUT: mask_input <= mask_wdata & `PFS_IN_SUPPORTED; // [RULE3]
        PFS_SEL_TEMP: mask_temp <= mask_wdata & `PFS_TEMP_SUPPORTED; // [RULE3]
        PFS_SEL_COMM: mask_comm <= mask_wdata & `PFS_COMM_SUPPORTED; // [RULE3]
        default: mask_iout <= mask_iout;
      endcase
    end
  end

  // readable input byte: latched flags plus the live off bit
  always_comb begin
    input_view = input_fb.flags;
    input_view[`PFS_IN_OFF_LIVE_BIT] = input_off_live_flag; // [RULE6]
  end

  // effective input mask: uv warning held masked until armed
  always_comb begin
    input_alert_mask = mask_input;
    if (!uvw_armed) begin
      input_alert_mask[`PFS_IN_UV_WARN_BIT] = 1'b1; // [RULE10]
    end
  end

  // alert request from unmasked latched flags only; live bit never enters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_req <= 1'b0;
    end else begin
      alert_req <= |(iout_fb.flags & ~mask_iout) // [RULE3] [RULE9]
                   | |(input_fb.flags & ~input_alert_mask) // [RULE7] [RULE8]
                   | |(temp_fb.flags & ~mask_temp)
                   | |(comm_fb.flags & ~mask_comm);
    end
  end

  // status word / status byte summary bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      iout_summary <= 1'b0;
      input_summary <= 1'b0;
      temp_summary <= 1'b0;
      comm_summary <= 1'b0;
    end else begin
      iout_summary <= |iout_fb.flags; // [RULE16] [RULE17]
      input_summary <= |input_fb.flags; // [RULE16] [RULE17]
      temp_summary <= |temp_fb.flags; // [RULE17]
      comm_summary <= |comm_fb.flags; // [RULE17]
    end
  end

  // one-byte read answer, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= `PFS_RDATA_RST;
    end else begin
      rsp_valid <= cmd_rd || mask_read; // [RULE13]
      if (cmd_rd) begin
        case (cmd_sel)
          PFS_SEL_IOUT: rsp_data <= iout_fb.flags; // [RULE2]
          PFS_SEL_INPUT: rsp_data <= input_view; // [RULE5]
          PFS_SEL_TEMP: rsp_data <= temp_fb.flags; // [RULE11]
          PFS_SEL_COMM: rsp_data <= comm_fb.flags; // [RULE15]
          default: rsp_data <= `PFS_RDATA_RST;
        endcase
      end else if (mask_read) begin
        case (mask_sel)
          PFS_SEL_IOUT: rsp_data <= mask_iout;
          PFS_SEL_INPUT: rsp_data <= mask_input;
          PFS_SEL_TEMP: rsp_data <= mask_temp;
          PFS_SEL_COMM: rsp_data <= mask_comm;
          default: rsp_data <= `PFS_RDATA_RST;
        endcase
      end else begin
        rsp_data <= `PFS_RDATA_RST;
      end
    end
  end

  // flag for an access to a code outside this block
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_unmapped <= 1'b0;
    end else begin
      rsp_unmapped <= (cmd_valid && cmd_sel == PFS_SEL_NONE)
                      || (!cmd_rd && mask_read && mask_sel == PFS_SEL_NONE)
                      || (mask_write && mask_sel == PFS_SEL_NONE);
    end
  end
endmodule

// >>> testbench/pfs_status_checker.sv
// concurrent checks on the fault status byte ports
`timescale 1ns/1ps
module pfs_status_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire pfs_pkg::pfs_byte_t cmd_code,
  input wire logic clear_faults,
  input wire logic mask_write,
  input wire logic mask_read,
  input wire logic overcurrent_fault_det,
  input wire logic overcurrent_warn_det,
  input wire logic undercurrent_fault_det,
  input wire logic input_overvoltage_fault_det,
  input wire logic input_overvoltage_warn_det,
  input wire logic input_undervoltage_warn_det,
  input wire logic power_input_above_turn_on_det,
  input wire logic power_input_below_turn_off_det,
  input wire logic internal_5v_rail_uvlo_det,
  input wire logic overtemp_fault_det,
  input wire logic overtemp_warn_det,
  input wire pfs_pkg::pfs_byte_t comm_event,
  input wire logic rsp_valid,
  input wire pfs_pkg::pfs_byte_t rsp_data,
  input wire logic rsp_unmapped,
  input wire logic alert_req,
  input wire logic iout_summary,
  input wire logic input_summary,
  input wire logic temp_summary,
  input wire logic comm_summary,
  input wire logic input_off_live_flag
);
  import pfs_pkg::*;
  logic any_det;
  logic any_sum;
  // any latched detector input, any summary output
  assign any_det = |{overcurrent_fault_det, overcurrent_warn_det, undercurrent_fault_det,
    input_overvoltage_fault_det, input_overvoltage_warn_det, input_undervoltage_warn_det,
    overtemp_fault_det, overtemp_warn_det};
  assign any_sum = |{iout_summary, input_summary, temp_summary, comm_summary};
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // event inputs quiet long enough to drain the synchronisers
  sequence s_quiet;
    !any_det [*4];
  endsequence
  sequence s_off;
    (power_input_below_turn_off_det || internal_5v_rail_uvlo_det) [*6];
  endsequence
  sequence s_on;
    (power_input_above_turn_on_det && !power_input_below_turn_off_det
      && !internal_5v_rail_uvlo_det) [*6];
  endsequence
  property p_zero(logic [7:0] code, logic [7:0] zm);
    rsp_valid && $past(cmd_valid && !cmd_write && cmd_code == code)
      |-> (rsp_data & zm) == 8'h00;
  endproperty
  AST_RSP_CAUSE: assert property (
    rsp_valid |-> $past(cmd_valid && !cmd_write || mask_read))
    else $error("read answer without request");
  AST_RDATA_IDLE: assert property (!rsp_valid |-> rsp_data == 8'h00)
    else $error("read data outside answer");
  AST_UNMAPPED: assert property (
    rsp_unmapped |-> rsp_data == 8'h00 && $past(cmd_valid || mask_write || mask_read))
    else $error("bad unmapped answer");
  AST_IOUT_ZERO: assert property (p_zero(8'h7B, 8'h4F))
    else $error("output current reserved bit set");
  AST_INPUT_ZERO: assert property (p_zero(8'h7C, 8'h17))
    else $error("input reserved bit set");
  AST_TEMP_ZERO: assert property (p_zero(8'h7D, 8'h3F))
    else $error("temperature reserved bit set");
  AST_OFF_RESET: assert property ($rose(nrst) |-> input_off_live_flag && !alert_req)
    else $error("bad state after reset");
  AST_OFF_LIVE: assert property (s_off |-> input_off_live_flag)
    else $error("input off not shown");
  AST_ON_LIVE: assert property (s_on |-> !input_off_live_flag)
    else $error("input on not shown");
  AST_ALERT_SUM: assert property (!any_sum |-> !alert_req)
    else $error("alert with no flag");
  AST_CLEAR_ALL: assert property (
    s_quiet ##0 (clear_faults && comm_event == 8'h00) |-> ##2 !any_sum)
    else $error("clear-faults left a flag");
  AST_HOLD: assert property (
    iout_summary && !$past(clear_faults) && !$past(cmd_valid && cmd_write) |=> iout_summary)
    else $error("flag dropped without clear");
endmodule
bind pfs_status_top pfs_status_checker u_chk (.sys_clk, .nrst, .cmd_valid, .cmd_write,
  .cmd_code, .clear_faults, .mask_write, .mask_read, .overcurrent_fault_det,
  .overcurrent_warn_det, .undercurrent_fault_det, .input_overvoltage_fault_det,
  .input_overvoltage_warn_det, .input_undervoltage_warn_det, .power_input_above_turn_on_det,
  .power_input_below_turn_off_det, .internal_5v_rail_uvlo_det, .overtemp_fault_det,
  .overtemp_warn_det, .comm_event, .rsp_valid, .rsp_data, .rsp_unmapped, .alert_req,
  .iout_summary, .input_summary, .temp_summary, .comm_summary, .input_off_live_flag);

// >>> testbench/pfs_host_model.sv
// host model issuing status byte reads, writes and clear-faults
`timescale 1ns/1ps
module pfs_host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output pfs_pkg::pfs_byte_t cmd_code,
  output pfs_pkg::pfs_byte_t cmd_wdata,
  output logic clear_faults,
  input wire logic rsp_valid,
  input wire pfs_pkg::pfs_byte_t rsp_data,
  input wire logic rsp_unmapped
);
  import pfs_pkg::*;
  // bus idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    clear_faults = 1'b0;
  end
  // one byte per transaction, entered and left at a falling edge
  task automatic op(input logic wr, input pfs_byte_t code, input pfs_byte_t wd,
      output pfs_byte_t rd, output logic unm);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wr ? wd : ~cmd_wdata; // ones clear flags, unused data churns
    clear_faults = 1'b0;
    @(negedge sys_clk);
    rd = (rsp_valid === 1'b1) ? rsp_data : 'x; // one data byte back
    unm = rsp_unmapped;
  endtask
  // clear every latched flag
  task automatic clr;
    cmd_valid = 1'b0;
    clear_faults = 1'b1;
    @(negedge sys_clk);
  endtask
  // release the bus for one cycle
  task automatic idle;
    cmd_valid = 1'b0;
    clear_faults = 1'b0;
    @(negedge sys_clk);
  endtask
endmodule

// >>> testbench/pfs_status_top_tb.sv
// self-checking bench for the fault status bytes
`timescale 1ns/1ps
module pfs_status_top_tb;
  import pfs_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic mask_write = 1'b0;
  logic mask_read = 1'b0;
  logic cmd_valid, cmd_write, clear_faults, rsp_valid, rsp_unmapped, alert_req, unm;
  logic iout_summary, input_summary, temp_summary, comm_summary, input_off_live_flag;
  logic on = 1'b0;
  logic seen = 1'b0;
  logic [10:0] det = 11'h200; // input below turn-off, no events
  pfs_byte_t cmd_code, cmd_wdata, rsp_data, rd;
  pfs_byte_t mask_code = 8'h00;
  pfs_byte_t mask_wdata = 8'h00;
  pfs_byte_t comm_event = 8'h00;
  pfs_byte_t exp [4];
  logic [31:0] r;
  integer seed = 32'h7f62_2976;
  integer error_cnt = 0;
  integer checked = 0;
  pfs_status_top DUT (.sys_clk, .nrst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .clear_faults, .mask_write, .mask_read, .mask_code, .mask_wdata,
    .overcurrent_fault_det(det[0]), .overcurrent_warn_det(det[1]),
    .undercurrent_fault_det(det[2]), .input_overvoltage_fault_det(det[3]),
    .input_overvoltage_warn_det(det[4]), .input_undervoltage_warn_det(det[5]),
    .overtemp_fault_det(det[6]), .overtemp_warn_det(det[7]),
    .power_input_above_turn_on_det(det[8]), .power_input_below_turn_off_det(det[9]),
    .internal_5v_rail_uvlo_det(det[10]), .comm_event, .rsp_valid, .rsp_data,
    .rsp_unmapped, .alert_req, .iout_summary, .input_summary, .temp_summary,
    .comm_summary, .input_off_live_flag);
  pfs_host_model host (.sys_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .clear_faults, .rsp_valid, .rsp_data, .rsp_unmapped);
  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic cmp_byte(input string name, input pfs_byte_t e, input pfs_byte_t g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic cmp_bit(input string name, input logic e, input logic g);
    cmp_byte(name, {7'h00, e}, {7'h00, g});
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // alert expected from latched flags, iout mask and undervoltage gate
  function automatic logic exp_alert(input pfs_byte_t m);
    return |{exp[0] & ~m, exp[1] & (seen ? 8'hFF : 8'hDF), exp[2], exp[3]};
  endfunction
  // pulse events for one cycle and let them latch
  task automatic hit(input logic [7:0] d, input pfs_byte_t ev);
    det[7:0] = d;
    comm_event = ev;
    @(negedge sys_clk);
    det[7:0] = 8'h00;
    comm_event = 8'h00;
    exp[0] |= {d[0], 1'b0, d[1], d[2], 4'h0};
    exp[1] |= {d[3], d[4], d[5], 5'h00};
    exp[2] |= {d[6], d[7], 6'h00};
    exp[3] |= ev;
    repeat (5) @(negedge sys_clk);
  endtask
  // one mask port access
  task automatic mk(input logic rdn, input pfs_byte_t code, input pfs_byte_t wd);
    mask_write = !rdn;
    mask_read = rdn;
    mask_code = code;
    mask_wdata = wd;
    @(negedge sys_clk);
    mask_write = 1'b0;
    mask_read = 1'b0;
  endtask
  // read all four bytes back to back, then the level outputs
  task automatic rd_all(input pfs_byte_t m);
    pfs_byte_t e;
    for (int k = 0; k < 4; k++) begin
      host.op(1'b0, 8'h7B + k[7:0], 8'h00, rd, unm);
      e = exp[k] | ((k == 1 && !on) ? 8'h08 : 8'h00);
      cmp_byte("status byte", e, rd);
    end
    host.idle();
    repeat (2) @(negedge sys_clk);
    cmp_bit("iout summary", |exp[0], iout_summary);
    cmp_bit("input summary", |exp[1], input_summary);
    cmp_bit("temp summary", |exp[2], temp_summary);
    cmp_bit("comm summary", |exp[3], comm_summary);
    cmp_bit("alert", exp_alert(m), alert_req);
    cmp_bit("input off", !on, input_off_live_flag);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    repeat (6) @(negedge sys_clk);
    exp = '{default: 8'h00};
    rd_all(8'h00);
    hit(8'h20, 8'h00);
    rd_all(8'h00);
    // input comes up, then the 5 V rail drops out and returns
    det[9:8] = 2'b01;
    on = 1'b1;
    seen = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd_all(8'h00);
    det[10] = 1'b1;
    on = 1'b0;
    repeat (6) @(negedge sys_clk);
    rd_all(8'h00);
    det[10] = 1'b0;
    on = 1'b1;
    repeat (6) @(negedge sys_clk);
    host.op(1'b1, 8'h7C, 8'h20, rd, unm);
    host.idle();
    exp[1] = 8'h00;
    // masked overcurrent fault latches without alert
    mk(1'b0, 8'h7B, 8'hFF);
    @(negedge sys_clk);
    mk(1'b1, 8'h7B, 8'h00);
    cmp_byte("mask", 8'hB0, rsp_data);
    hit(8'h01, 8'h00);
    rd_all(8'hB0);
    mk(1'b0, 8'h7B, 8'h00);
    rd_all(8'h00);
    // masks of the other bytes keep only their alert-capable bits
    for (int k = 1; k < 4; k++) begin
      mk(1'b0, 8'h7B + k[7:0], 8'hFF);
      @(negedge sys_clk);
      mk(1'b1, 8'h7B + k[7:0], 8'h00);
      cmp_byte("mask", (k == 1) ? 8'hE0 : ((k == 2) ? 8'hC0 : 8'hFF), rsp_data);
      @(negedge sys_clk);
      mk(1'b0, 8'h7B + k[7:0], 8'h00);
      @(negedge sys_clk);
    end
    host.op(1'b0, 8'h7F, 8'h00, rd, unm);
    host.idle();
    cmp_bit("unmapped", 1'b1, unm);
    // clear-faults on a quiet bus empties every byte
    host.clr();
    host.idle();
    exp = '{default: 8'h00};
    rd_all(8'h00);
    // random events, cleared by clear-faults or written ones
    repeat (12) begin
      r = $random(seed);
      hit(r[7:0], r[15:8]);
      rd_all(8'h00);
      if (r[16]) begin
        host.clr();
        exp = '{default: 8'h00};
      end else begin
        for (int k = 0; k < 4; k++) begin
          host.op(1'b1, 8'h7B + k[7:0], r[31:24], rd, unm);
          exp[k] &= ~r[31:24];
        end
      end
      host.idle();
      rd_all(8'h00);
    end
    test_done();
  end
endmodule
